// file: design/sebsf_pkg.sv
/*
  Constants for the two-wire serial memory slave front end: address
  prefix, filter and timer counts, state codes.
  Assumes a 50 MHz system clock and a 15 ns link sampling clock.
*/
package sebsf_pkg;

  // ----------------------------------------------------------------
  // Clock rates
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 50;
  localparam int LINK_CLK_PERIOD_NS = 15;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int POWER_UP_READY_DELAY_MS = 1;
  localparam int POWER_UP_READY_CYCLES = POWER_UP_READY_DELAY_MS * 1000 * CLK_FREQ_MHZ;
  localparam int INTERNAL_PROGRAM_TIME_MS = 5;
  localparam int INTERNAL_PROGRAM_CYCLES = INTERNAL_PROGRAM_TIME_MS * 1000 * CLK_FREQ_MHZ;
  localparam int NOISE_PULSE_NS = 100;
  // A pulse of this length can cover ceil(ns/period) samples; one more rejects it
  localparam int FILTER_CYCLES =
    (NOISE_PULSE_NS + LINK_CLK_PERIOD_NS - 1) / LINK_CLK_PERIOD_NS + 1;
  localparam int TIMER_W = 18;
  localparam int FILT_W = 4;

  // ----------------------------------------------------------------
  // Address byte layout
  // ----------------------------------------------------------------
  localparam logic [3:0] TYPE_PREFIX = 4'hA;
  localparam int PREFIX_MSB = 7;
  localparam int PREFIX_LSB = 4;
  localparam int STRAP_MSB = 3;
  localparam int STRAP_LSB = 1;
  localparam int RW_BIT = 0;
  localparam logic [2:0] STRAP_FIXED = 3'h0;
  localparam logic [7:0] READ_FILL = 8'hFF;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] FIRST_DATA_BYTE = 2'h2;

  // ----------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEBSF_M_RESET = 2'b00,
    SEBSF_M_POWERUP = 2'b01,
    SEBSF_M_READY = 2'b10
  } sebsf_main_t;

  typedef enum logic [2:0] {
    SEBSF_L_IDLE = 3'b000,
    SEBSF_L_ADDR = 3'b001,
    SEBSF_L_ACK = 3'b010,
    SEBSF_L_WRX = 3'b011,
    SEBSF_L_RTX = 3'b100,
    SEBSF_L_RACK = 3'b101
  } sebsf_link_t;

endpackage : sebsf_pkg

// file: design/sebsf_front.sv
/*
  Two-wire serial memory slave front end: bus condition detection,
  slave address decode, open-drain data drive, write inhibit, power-on
  sequencing and program-cycle busy.
  Assumes link_clk is a free-running sampling clock well above the
  serial clock rate, and that pads hold unconnected straps low.
*/
// What this block does
// [RULE_01] Act only as slave; ignore the bus until a START is seen.
// [RULE_02] START is data falling while serial clock is high.
// [RULE_03] STOP is data rising while serial clock high; it ends any command.
// [RULE_04] Master keeps data stable while serial clock is high outside conditions.
// [RULE_05] Sample data on clock rise; change outgoing data on clock fall.
// [RULE_06] Drive data open-drain: pull low for zero, release for one.
// [RULE_07] Receive 8-bit address after START; top four bits must match prefix.
// [RULE_08] Next three address bits must equal the three strap inputs.
// [RULE_09] Strapless package variant treats strap bits as fixed zero.
// [RULE_10] Address LSB one means read, zero means write.
// [RULE_11] An unconnected strap input reads as low.
// [RULE_12] Write inhibit high blocks writes; unconnected reads low.
// [RULE_13] Variant without write inhibit always permits writes.
// [RULE_14] Standby above supply threshold; back to reset below it.
// [RULE_15] Ready for commands within 1 ms of stable supply; ready rises about 4 cycles after the full 1 ms count.
// [RULE_16] Reject noise pulses up to 100 ns on clock and data.
// [RULE_17] Master starts a transfer only on an idle bus after STOP.
// [RULE_18] Master generates the serial clock; device never drives it.
// [RULE_19] Ninth clock: transmitter releases data, receiver acks low or leaves high.
// [RULE_20] STOP after write starts program cycle; no acks meanwhile.
// [RULE_21] Sample write inhibit on last fall before first data byte; high rejects.
// [RULE_22] Address mismatch: release data and ignore bus until next START.
// [RULE_23] START mid-transfer aborts the byte and restarts address reception.
`timescale 1ns/100ps

// Holds its output until the input has differed for CYCLES samples
module sebsf_glitch #(
  parameter int CYCLES = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic raw_in,
  output logic filt_out
);
  import sebsf_pkg::*;

  logic [FILT_W-1:0] cnt_reg;

  // [RULE_16] noise pulse rejection
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
      filt_out <= 1'b1;
    end else if (raw_in == filt_out) begin
      cnt_reg <= '0;
    end else if (cnt_reg == FILT_W'(CYCLES - 1)) begin
      cnt_reg <= '0;
      filt_out <= raw_in;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule : sebsf_glitch

module sebsf_front
  import sebsf_pkg::*;
#(
  parameter int PU_CYCLES = POWER_UP_READY_CYCLES,
  parameter int PROG_CYCLES = INTERNAL_PROGRAM_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic supply_ok,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic chip_select_strap_0,
  input wire logic chip_select_strap_1,
  input wire logic chip_select_strap_2,
  input wire logic write_inhibit,
  input wire logic no_strap_variant,
  input wire logic no_wp_variant,
  output logic ready,
  output logic program_busy,
  output logic start_seen,
  output logic stop_seen,
  output logic write_rejected
);

  // ----------------------------------------------------------------
  // System domain
  // ----------------------------------------------------------------
  localparam int MS = 5;
  logic [MS-1:0] msync_a_reg;
  logic [MS-1:0] msync_b_reg;
  logic [MS-2:0] mtgl_prev_reg;
  logic [MS-2:0] mtgl_edge;
  sebsf_main_t main_state_reg;
  logic [TIMER_W-1:0] pu_cnt_reg;
  logic [TIMER_W-1:0] prog_cnt_reg;

  // Link-domain toggles, each flips once per event
  logic start_tgl_reg;
  logic stop_tgl_reg;
  logic reject_tgl_reg;
  logic prog_tgl_reg;

  // Supply level and event toggles cross on two flops
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      msync_a_reg <= '0;
      msync_b_reg <= '0;
      mtgl_prev_reg <= '0;
    end else begin
      msync_a_reg <= {supply_ok, prog_tgl_reg, reject_tgl_reg, stop_tgl_reg, start_tgl_reg};
      msync_b_reg <= msync_a_reg;
      mtgl_prev_reg <= msync_b_reg[MS-2:0];
    end
  end

  assign mtgl_edge = msync_b_reg[MS-2:0] ^ mtgl_prev_reg;

  // [RULE_14] supply sequencing; a brown-out drops straight back to reset
  always_ff @(posedge clock) begin
    if (sys_rst || !msync_b_reg[MS-1]) begin
      main_state_reg <= SEBSF_M_RESET;
      pu_cnt_reg <= '0;
    end else begin
      unique case (main_state_reg)
        SEBSF_M_RESET: begin
          main_state_reg <= SEBSF_M_POWERUP;
        end
        // [RULE_15] ready once the full power-up delay has run out
        SEBSF_M_POWERUP: begin
          if (pu_cnt_reg == TIMER_W'(PU_CYCLES - 1)) begin
            main_state_reg <= SEBSF_M_READY;
          end else begin
            pu_cnt_reg <= pu_cnt_reg + 1'b1;
          end
        end
        SEBSF_M_READY: begin
          main_state_reg <= SEBSF_M_READY;
        end
        default: begin
          main_state_reg <= SEBSF_M_RESET;
        end
      endcase
    end
  end

  // [RULE_20] program cycle timer holds the device busy
  always_ff @(posedge clock) begin
    if (sys_rst || main_state_reg != SEBSF_M_READY) begin
      program_busy <= 1'b0;
      prog_cnt_reg <= '0;
    end else if (program_busy) begin
      if (prog_cnt_reg == TIMER_W'(PROG_CYCLES - 1)) begin
        program_busy <= 1'b0;
        prog_cnt_reg <= '0;
      end else begin
        prog_cnt_reg <= prog_cnt_reg + 1'b1;
      end
    end else if (mtgl_edge[3]) begin
      program_busy <= 1'b1;
    end
  end

  // Status outputs; events are hidden until the device is ready
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ready <= 1'b0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
      write_rejected <= 1'b0;
    end else begin
      ready <= (main_state_reg == SEBSF_M_READY);
      start_seen <= ready && mtgl_edge[0];
      stop_seen <= ready && mtgl_edge[1];
      write_rejected <= ready && mtgl_edge[2];
    end
  end

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  localparam int LS = 10;
  logic [LS-1:0] lsync_a_reg;
  logic [LS-1:0] lsync_b_reg;
  logic link_rst;
  logic scl_f;
  logic sda_f;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [2:0] strap_eff;
  logic wp_eff;
  logic busy_l;
  sebsf_link_t link_state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [1:0] byte_cnt_reg;
  logic rw_reg;
  logic wp_block_reg;
  logic data_taken_reg;
  logic nack_reg;

  // Pins and system levels pass two flops before any logic
  always_ff @(posedge link_clk) begin
    lsync_a_reg <= {program_busy, ready, no_wp_variant, no_strap_variant, write_inhibit,
                    chip_select_strap_2, chip_select_strap_1, chip_select_strap_0,
                    sda_in, scl_in};
    lsync_b_reg <= lsync_a_reg;
  end

  // Link logic is held reset until the device is ready
  assign link_rst = !lsync_b_reg[8];
  assign busy_l = lsync_b_reg[9];
  // [RULE_09] strapless variant answers only to zero straps
  // [RULE_11] straps are pulled low at the pad when left open
  assign strap_eff = lsync_b_reg[6] ? STRAP_FIXED : lsync_b_reg[4:2];
  // [RULE_12] write inhibit high blocks writes
  // [RULE_13] variant without inhibit pin always writes
  assign wp_eff = !lsync_b_reg[7] && lsync_b_reg[5];

  sebsf_glitch #(.CYCLES(FILTER_CYCLES)) u_scl_filt (
    .clk(link_clk),
    .rst(link_rst),
    .raw_in(lsync_b_reg[0]),
    .filt_out(scl_f)
  );

  sebsf_glitch #(.CYCLES(FILTER_CYCLES)) u_sda_filt (
    .clk(link_clk),
    .rst(link_rst),
    .raw_in(lsync_b_reg[1]),
    .filt_out(sda_f)
  );

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_f;
      sda_prev_reg <= sda_f;
    end
  end

  // [RULE_18] serial clock is only ever sensed, never driven
  assign scl_rise = scl_f && !scl_prev_reg;
  assign scl_fall = !scl_f && scl_prev_reg;
  // [RULE_02] start condition detect
  assign start_det = scl_f && scl_prev_reg && sda_prev_reg && !sda_f;
  // [RULE_03] stop condition detect
  assign stop_det = scl_f && scl_prev_reg && !sda_prev_reg && sda_f;

  // Transfer sequencing; sda_out stays low so enable alone pulls the line
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      link_state_reg <= SEBSF_L_IDLE;
      shift_reg <= '0;
      bit_cnt_reg <= '0;
      byte_cnt_reg <= '0;
      rw_reg <= 1'b0;
      wp_block_reg <= 1'b0;
      data_taken_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      start_tgl_reg <= 1'b0;
      stop_tgl_reg <= 1'b0;
      reject_tgl_reg <= 1'b0;
      prog_tgl_reg <= 1'b0;
    end else if (start_det) begin
      // [RULE_23] a start anywhere restarts address reception
      link_state_reg <= SEBSF_L_ADDR;
      bit_cnt_reg <= '0;
      byte_cnt_reg <= '0;
      data_taken_reg <= 1'b0;
      sda_oe <= 1'b0;
      start_tgl_reg <= !start_tgl_reg;
    end else if (stop_det) begin
      // [RULE_20] stop after accepted data launches programming
      if (!rw_reg && data_taken_reg) begin
        prog_tgl_reg <= !prog_tgl_reg;
      end
      link_state_reg <= SEBSF_L_IDLE;
      data_taken_reg <= 1'b0;
      sda_oe <= 1'b0;
      stop_tgl_reg <= !stop_tgl_reg;
    end else begin
      unique case (link_state_reg)
        // [RULE_01] idle ignores all traffic until a start
        SEBSF_L_IDLE: begin
          sda_oe <= 1'b0;
        end
        SEBSF_L_ADDR: begin
          // [RULE_05] sample on rise
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_f};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
          end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
            // [RULE_07] type prefix must match
            // [RULE_08] straps must match
            // [RULE_20] no address ack while programming
            if (shift_reg[PREFIX_MSB:PREFIX_LSB] == TYPE_PREFIX &&
                shift_reg[STRAP_MSB:STRAP_LSB] == strap_eff && !busy_l) begin
              // [RULE_10] direction bit
              rw_reg <= shift_reg[RW_BIT];
              // [RULE_19] receiver acks by pulling low
              sda_oe <= 1'b1;
              link_state_reg <= SEBSF_L_ACK;
            end else begin
              // [RULE_22] mismatch waits for the next start
              link_state_reg <= SEBSF_L_IDLE;
            end
          end
        end
        SEBSF_L_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= '0;
            if (rw_reg) begin
              // [RULE_06] drive low only for a zero
              shift_reg <= {READ_FILL[6:0], 1'b0};
              sda_oe <= !READ_FILL[7];
              bit_cnt_reg <= 4'h1;
              link_state_reg <= SEBSF_L_RTX;
            end else begin
              // [RULE_21] inhibit strobed on the fall before first data byte
              if (byte_cnt_reg == FIRST_DATA_BYTE) begin
                wp_block_reg <= wp_eff;
              end
              sda_oe <= 1'b0;
              link_state_reg <= SEBSF_L_WRX;
            end
          end
        end
        SEBSF_L_WRX: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_f};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
          end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
            if (byte_cnt_reg == FIRST_DATA_BYTE && wp_block_reg) begin
              // [RULE_21] inhibited write gets no ack
              reject_tgl_reg <= !reject_tgl_reg;
              link_state_reg <= SEBSF_L_IDLE;
            end else begin
              if (byte_cnt_reg == FIRST_DATA_BYTE) begin
                data_taken_reg <= 1'b1;
              end else begin
                byte_cnt_reg <= byte_cnt_reg + 1'b1;
              end
              sda_oe <= 1'b1;
              link_state_reg <= SEBSF_L_ACK;
            end
          end
        end
        SEBSF_L_RTX: begin
          // [RULE_05] outgoing bits change on fall
          if (scl_fall) begin
            if (bit_cnt_reg == BITS_PER_BYTE) begin
              // [RULE_19] transmitter releases for the ninth clock
              sda_oe <= 1'b0;
              link_state_reg <= SEBSF_L_RACK;
            end else begin
              sda_oe <= !shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 1'b1;
            end
          end
        end
        SEBSF_L_RACK: begin
          if (scl_rise) begin
            nack_reg <= sda_f;
          end else if (scl_fall) begin
            if (nack_reg) begin
              link_state_reg <= SEBSF_L_IDLE;
            end else begin
              shift_reg <= {READ_FILL[6:0], 1'b0};
              sda_oe <= !READ_FILL[7];
              bit_cnt_reg <= 4'h1;
              link_state_reg <= SEBSF_L_RTX;
            end
          end
        end
        default: begin
          link_state_reg <= SEBSF_L_IDLE;
        end
      endcase
    end
  end

endmodule : sebsf_front

// file: dv/sebsf_front_assertions.sv
/*
  Port checker for the serial memory front end.
  Assumes it is bound to every sebsf_front instance.
*/
`timescale 1ns/100ps
module sebsf_front_checker #(
  parameter int PU_CYCLES = 20,
  parameter int PROG_CYCLES = 200
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic supply_ok,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic ready,
  input wire logic program_busy,
  input wire logic start_seen,
  input wire logic stop_seen,
  input wire logic write_rejected
);
  int up_cnt;
  int busy_cnt;
  // Cycles of supply up since reset; saturates so it cannot wrap
  always_ff @(posedge clock) begin
    if (sys_rst || !supply_ok) up_cnt <= 0;
    else if (up_cnt < PU_CYCLES + 64) up_cnt <= up_cnt + 1;
  end
  // Length of the current busy spell
  always_ff @(posedge clock) begin
    if (sys_rst || !program_busy) busy_cnt <= 0;
    else busy_cnt <= busy_cnt + 1;
  end
  a_rst_quiet: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(sys_rst) |-> !ready && !program_busy && !start_seen && !write_rejected)
    else $error("outputs not quiet after reset");
  a_ready_late: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(ready) |-> up_cnt >= PU_CYCLES) else $error("ready too early");
  a_ready_due: assert property (@(posedge clock) disable iff (sys_rst)
    up_cnt == PU_CYCLES + 10 |-> ready) else $error("ready too late");
  a_brown_out: assert property (@(posedge clock) disable iff (sys_rst)
    !supply_ok [*4] |=> !ready) else $error("ready kept on supply loss");
  a_start_ready: assert property (@(posedge clock) disable iff (sys_rst)
    start_seen |-> ready ##1 !start_seen) else $error("bad start pulse");
  a_reject_pulse: assert property (@(posedge clock) disable iff (sys_rst)
    write_rejected |=> !write_rejected && !program_busy) else $error("bad reject pulse");
  a_busy_span: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(program_busy) |-> $past(busy_cnt) >= PROG_CYCLES - 2 &&
    $past(busy_cnt) < PROG_CYCLES + 4) else $error("busy span wrong");
  a_oe_scl_low: assert property (@(posedge link_clk) disable iff (sys_rst)
    $changed(sda_oe) |-> !scl_in) else $error("data changed with clock high");
  a_open_drain: assert property (@(posedge link_clk) disable iff (sys_rst)
    sda_oe |-> sda_out == 1'b0) else $error("data driven high");
  a_ack_holds: assert property (@(posedge link_clk) disable iff (sys_rst)
    $rose(sda_oe) |=> sda_oe [*8]) else $error("ack too short");
endmodule : sebsf_front_checker

bind sebsf_front sebsf_front_checker #(.PU_CYCLES(PU_CYCLES), .PROG_CYCLES(PROG_CYCLES)) u_chk (
  .clock(clock), .sys_rst(sys_rst), .link_clk(link_clk), .supply_ok(supply_ok),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .ready(ready),
  .program_busy(program_busy), .start_seen(start_seen), .stop_seen(stop_seen),
  .write_rejected(write_rejected));

// file: dv/sebsf_master_model.sv
/*
  Behavioural two-wire bus master driving the serial clock and data.
  Assumes a pull-up on both lines; steps on falling edges of clk.
*/
`timescale 1ns/100ps
module sebsf_master_model #(
  parameter int H = 50
) (
  input wire logic clk,
  output logic scl,
  output logic sda_m,
  input wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hp(input int n);
    repeat (n) @(negedge clk);
  endtask : hp
  task automatic start();
    hp(H / 4); sda_m = 1'b1; hp(H); scl = 1'b1; hp(H);
    sda_m = 1'b0; hp(H); scl = 1'b0;
  endtask : start
  task automatic stop();
    hp(H / 4); sda_m = 1'b0; hp(H); scl = 1'b1; hp(H);
    sda_m = 1'b1; hp(2 * H);
  endtask : stop
  // data moves only while clock low
  task automatic bit_io(input logic b, output logic r);
    hp(H / 4); sda_m = b; hp(H); scl = 1'b1; hp(H / 2);
    r = sda_line; hp(H / 2); scl = 1'b0;
  endtask : bit_io
  // eight bits then the answer bit
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, a);
  endtask : xfer
  // Short low pulse on data with clock high, shorter than the filter span
  task automatic glitch();
    hp(H); sda_m = 1'b0; hp(3); sda_m = 1'b1; hp(H);
  endtask : glitch
endmodule : sebsf_master_model

// file: dv/tb.sv
/*
  Self-checking bench for the serial memory front end.
  Assumes the master model and the bound checker are compiled before.
*/
`timescale 1ns/100ps
module tb;
  import sebsf_pkg::*;
  localparam int PU = 20;
  localparam int PROG = 2000;
  logic clock = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic supply_ok = 1'b1;
  logic [2:0] strap = 3'h0;
  logic write_inhibit = 1'b0;
  logic no_strap_variant = 1'b0;
  logic no_wp_variant = 1'b0;
  logic scl, sda_m, sda_line, sda_out, sda_oe;
  logic ready, program_busy, start_seen, stop_seen, write_rejected;
  logic a;
  logic [7:0] q;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_start = 0;
  int n_rej = 0;
  int n_stop = 0;
  always #10 clock = ~clock;
  // Link clock offset so its edges drift against the system clock
  initial begin
    #3;
    forever #7.5 link_clk = ~link_clk;
  end
  // Open-drain line: anyone pulling low wins over the pull-up
  assign sda_line = sda_m & ~(sda_oe & ~sda_out);
  sebsf_front #(.PU_CYCLES(PU), .PROG_CYCLES(PROG)) u_sebsf_front (
    .clock(clock), .sys_rst(sys_rst), .link_clk(link_clk), .supply_ok(supply_ok),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_strap_0(strap[0]), .chip_select_strap_1(strap[1]),
    .chip_select_strap_2(strap[2]), .write_inhibit(write_inhibit),
    .no_strap_variant(no_strap_variant), .no_wp_variant(no_wp_variant), .ready(ready),
    .program_busy(program_busy), .start_seen(start_seen), .stop_seen(stop_seen),
    .write_rejected(write_rejected));
  sebsf_master_model u_sebsf_master_model (.clk(clock), .scl(scl), .sda_m(sda_m),
    .sda_line(sda_line));
  // Pulse counters
  always @(posedge clock) begin
    if (start_seen === 1'b1) n_start++;
    if (write_rejected === 1'b1) n_rej++;
    if (stop_seen === 1'b1) n_stop++;
  end
  task automatic results();
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %b got %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk_val
  function automatic logic [7:0] adr(input logic [2:0] s, input logic r);
    return {4'hA, s, r};
  endfunction : adr
  task automatic wr(input logic [7:0] d, input logic ack);
    u_sebsf_master_model.xfer(d, 1'b1, q, a);
    chk_bit("ack", ack, ~a);
  endtask : wr
  task automatic rd(input logic mack);
    u_sebsf_master_model.xfer(8'hFF, ~mack, q, a);
    chk_val("rdata", 8'hFF, q);
  endtask : rd
  task automatic wseq(input logic [2:0] s, input logic dack);
    wr(adr(s, 1'b0), 1'b1); wr(8'h01, 1'b1); wr(8'h23, 1'b1); wr(8'h5A, dack);
  endtask : wseq
  task automatic wait_ready();
    for (int i = 0; i < PU + 40 && ready !== 1'b1; i++) @(negedge clock);
    chk_bit("ready", 1'b1, ready);
    repeat (60) @(negedge clock);
  endtask : wait_ready
  task automatic wait_idle();
    for (int i = 0; i < PROG + 200 && program_busy !== 1'b0; i++) @(negedge clock);
    chk_bit("busy_end", 1'b0, program_busy);
  endtask : wait_idle
  // Addresses that must be ignored: prefix or strap wrong
  logic [7:0] bad [4] = '{8'hBA, 8'hA8, 8'hA3, 8'h2A};
  initial begin
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    chk_bit("ready_rst", 1'b0, ready);
    wait_ready();
    strap = 3'h5;
    u_sebsf_master_model.glitch();
    chk_val("glitch", 8'h00, 8'(n_start));
    u_sebsf_master_model.start();
    wseq(3'h5, 1'b1);
    u_sebsf_master_model.stop();
    chk_val("starts", 8'h01, 8'(n_start));
    chk_val("stops", 8'h01, 8'(n_stop));
    chk_bit("busy", 1'b1, program_busy);
    u_sebsf_master_model.start();
    wr(adr(3'h5, 1'b0), 1'b0);
    u_sebsf_master_model.stop();
    wait_idle();
    foreach (bad[i]) begin
      u_sebsf_master_model.start();
      wr(bad[i], 1'b0);
      wr(adr(3'h5, 1'b0), 1'b0);
      u_sebsf_master_model.stop();
    end
    u_sebsf_master_model.start();
    for (int i = 0; i < 4; i++) u_sebsf_master_model.bit_io(1'b1, a);
    u_sebsf_master_model.start();
    wr(adr(3'h5, 1'b0), 1'b1);
    wr(8'h00, 1'b1);
    u_sebsf_master_model.start();
    wr(adr(3'h5, 1'b1), 1'b1);
    rd(1'b1);
    rd(1'b0);
    u_sebsf_master_model.stop();
    chk_bit("busy_rd", 1'b0, program_busy);
    write_inhibit = 1'b1;
    u_sebsf_master_model.start();
    wseq(3'h5, 1'b0);
    u_sebsf_master_model.stop();
    chk_val("rejects", 8'h01, 8'(n_rej));
    chk_bit("busy_wp", 1'b0, program_busy);
    no_wp_variant = 1'b1;
    u_sebsf_master_model.start();
    wseq(3'h5, 1'b1);
    u_sebsf_master_model.stop();
    chk_bit("busy_nowp", 1'b1, program_busy);
    wait_idle();
    write_inhibit = 1'b0;
    no_wp_variant = 1'b0;
    no_strap_variant = 1'b1;
    u_sebsf_master_model.start();
    wr(adr(3'h5, 1'b1), 1'b0);
    u_sebsf_master_model.start();
    wr(adr(3'h0, 1'b1), 1'b1);
    rd(1'b0);
    u_sebsf_master_model.stop();
    supply_ok = 1'b0;
    repeat (8) @(negedge clock);
    chk_bit("ready_low", 1'b0, ready);
    supply_ok = 1'b1;
    wait_ready();
    u_sebsf_master_model.start();
    wr(adr(3'h0, 1'b1), 1'b1);
    rd(1'b0);
    u_sebsf_master_model.stop();
    results();
  end
  // Watchdog above the expected run of about 39000 cycles, below the run budget
  initial begin
    repeat (90000) @(posedge clock);
    n_mismatch++;
    results();
  end
endmodule : tb
